/* File: core/pbs_pkg.sv */
// Purpose: Shared constants and types of the pipelined burst memory port.
// Assumes: Wide organisation by default; narrow one set by parameters.
// Notes:   Every width, count and encoding used by the design lives here.
package pbs_pkg;
   // Wide organisation: 512K words of four 9-bit lanes.
   localparam int WIDE_ADDR_W   = 19;
   localparam int WIDE_LANES    = 4;
   // Narrow organisation: 1M words of two 9-bit lanes.
   localparam int NARROW_ADDR_W = 20;
   localparam int NARROW_LANES  = 2;
   localparam int LANE_W        = 9;
   // Burst counter width and its first and step values.
   localparam int            BURST_W     = 2;
   localparam logic [1:0]    BURST_FIRST = 2'h0;
   localparam logic [1:0]    BURST_STEP  = 2'h1;
   // Depth of the posted-write queue.
   localparam int            WQ_DEPTH    = 16;
   // Burst order select levels.
   localparam logic          ORDER_LINEAR = 1'h1;

   // Access mode of the current burst, Gray coded along idle-read-write.
   typedef enum logic [1:0] {
      PBS_IDLE  = 2'b00,
      PBS_READ  = 2'b01,
      PBS_WRITE = 2'b11
   } pbs_mode_e;
endpackage : pbs_pkg

/* File: core/pbs_fifo.sv */
// Purpose: Parameterised first-in first-out queue with valid and ready.
// Assumes: DEPTH is a power of two; one clock, asynchronous reset.
// Notes:   Head word is shown combinationally from registered storage.
`timescale 1ns/1ns
module pbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] store;
      logic [PW-1:0]               wrPtr;
      logic [PW-1:0]               rdPtr;
      logic [CW-1:0]               count;
   } pbs_fifo_s;

   pbs_fifo_s cur;
   pbs_fifo_s next_cur;
   logic      push;
   logic      pop;

   // Full and empty follow the occupancy count exactly.
   assign inReady  = (cur.count != CW'(DEPTH));
   assign outValid = (cur.count != '0);
   assign outData  = cur.store[cur.rdPtr];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // Pointers and count advance on accepted pushes and pops.
   always_comb begin
      next_cur = cur;
      if (push) begin
         next_cur.store[cur.wrPtr] = inData;
         next_cur.wrPtr = cur.wrPtr + PW'(1);
      end
      if (pop) begin
         next_cur.rdPtr = cur.rdPtr + PW'(1);
      end
      if (push && !pop) begin
         next_cur.count = cur.count + CW'(1);
      end else if (pop && !push) begin
         next_cur.count = cur.count - CW'(1);
      end
   end

   // State register.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end
endmodule : pbs_fifo

/* File: core/pbs_array.sv */
// Purpose: Byte-lane storage array with one write and one read port.
// Assumes: Read data are registered; write and read may hit one word.
// Notes:   A read of a word written on the same edge returns new lanes.
`timescale 1ns/1ns
module pbs_array #(
   parameter int ADDR_W = 19,
   parameter int LANES  = 4,
   parameter int LANE_W = 9
) (
   input  wire logic                    clock,
   input  wire logic                    writeEnable,
   input  wire logic [ADDR_W-1:0]       writeAddr,
   input  wire logic [LANES*LANE_W-1:0] writeData,
   input  wire logic [LANES-1:0]        writeLanes,
   input  wire logic                    readEnable,
   input  wire logic [ADDR_W-1:0]       readAddr,
   output logic      [LANES*LANE_W-1:0] readData
);
   localparam int WORDS = 2 ** ADDR_W;

   // One bank per lane so each lane is written on its own select.
   for (genvar i = 0; i < LANES; i++) begin : gLane
      logic [LANE_W-1:0] bank [WORDS];
      logic [LANE_W-1:0] laneQ;
      logic              hit;

      assign hit = writeEnable & writeLanes[i] & (writeAddr == readAddr);
      assign readData[i*LANE_W +: LANE_W] = laneQ;

      // Lane write, then registered read with write-through bypass.
      always_ff @(posedge clock) begin
         if (writeEnable && writeLanes[i]) begin
            bank[writeAddr] <= writeData[i*LANE_W +: LANE_W];
         end
         if (readEnable) begin
            laneQ <= hit ? writeData[i*LANE_W +: LANE_W] : bank[readAddr];
         end
      end
   end
endmodule : pbs_array

/* File: core/pbs_port.sv */
// Purpose: Synchronous bus port of a pipelined burst static memory.
// Assumes: The master keeps setup to the rising edge of clock.
// Notes:   Writes are posted through a queue; reads see queued heads.
//
// Summary of operation
// - All synchronous inputs registered on rising edge.
// - Output enable and sleep act without strobes.
// - Address and selects load only on strobes.
// - Later burst addresses generated internally on advance.
// - Two-bit counter, bursts wrap after four.
// - Interleaved or linear order from static select.
// - Writes registered, then completed self-timed internally.
// - Only selected byte lanes are written.
// - All-lanes write low writes every lane.
// - Inputs and read outputs registered, reads pipelined.
// - Burst read timing three then one each.
// - Outputs deselect three cycles after selects inactive.
// - Depth and width follow chosen organisation.
// - Access needs all three chip selects active.
// - Processor or controller strobe starts access.
// - Low address bits seed the burst counter.
// - Lane writes need qualifier low at edge.
// - Counter steps only when advance sampled low.
`timescale 1ns/1ns
module pbs_port
   import pbs_pkg::*;
#(
   parameter int ADDR_W   = WIDE_ADDR_W,
   parameter int LANES    = WIDE_LANES,
   parameter int QUEUE_D  = WQ_DEPTH
) (
   input  wire logic                    clock,
   input  wire logic                    reset,
   input  wire logic [ADDR_W-1:0]       address,
   input  wire logic                    processorAddressStrobe_n,
   input  wire logic                    controllerAddressStrobe_n,
   input  wire logic                    burstAdvance_n,
   input  wire logic                    allLanesWrite_n,
   input  wire logic                    laneWriteQualifier_n,
   input  wire logic [LANES-1:0]        byteLaneWriteSelect_n,
   input  wire logic                    pipelinedChipSelect_n,
   input  wire logic                    depthChipSelectHigh,
   input  wire logic                    depthChipSelectLow_n,
   input  wire logic                    burstOrderLinear,
   input  wire logic                    outputEnable_n,
   input  wire logic                    sleepRequest,
   input  wire logic [LANES*LANE_W-1:0] dataPinIn,
   output logic      [LANES*LANE_W-1:0] dataPinOut,
   output logic                         dataPinEnable,
   output logic                         writeQueueReady
);
   localparam int DW = LANES * LANE_W;
   localparam int QW = ADDR_W + DW + LANES;

   typedef struct packed {
      // Two-stage synchronisers of the unclocked pins.
      logic              oeMeta_n;
      logic              oeSync_n;
      logic              sleepMeta;
      logic              sleepSync;
      // Input capture stage.
      logic [ADDR_W-1:0] inAddr;
      logic [DW-1:0]     inData;
      logic              inProcStrobe_n;
      logic              inCtrlStrobe_n;
      logic              inAdvance_n;
      logic              inAllWrite_n;
      logic              inLaneQual_n;
      logic [LANES-1:0]  inLaneSel_n;
      logic              inSel1_n;
      logic              inSel2;
      logic              inSel3_n;
      logic              inOrder;
      // Burst state.
      pbs_mode_e         mode;
      logic [ADDR_W-1:0] baseAddr;
      logic [BURST_W-1:0] startOffset;
      logic [BURST_W-1:0] count;
      // Output pipeline.
      logic              readPending;
      logic [DW-1:0]     dataOut;
      logic              dataEnable;
      logic              queueReady;
   } pbs_port_s;

   pbs_port_s         cur;
   pbs_port_s         next_cur;
   logic              strobe;
   logic              selected;
   logic [LANES-1:0]  writeLanes;
   logic              isWrite;
   logic              doRead;
   logic              doWrite;
   logic [ADDR_W-1:0] accessAddr;
   logic [BURST_W-1:0] stepCount;
   logic              qInReady;
   logic              qOutValid;
   logic [QW-1:0]     qOutData;
   logic [DW-1:0]     arrayRead;

   // Burst offset from start and count in the selected order.
   function automatic logic [BURST_W-1:0] burstOffset(
      input logic               linear,
      input logic [BURST_W-1:0] start,
      input logic [BURST_W-1:0] cnt
   );
      return (linear == ORDER_LINEAR) ? start + cnt : start ^ cnt;
   endfunction : burstOffset

   // Decode of the captured strobes, selects and write controls.
   always_comb begin
      strobe = !cur.inProcStrobe_n || !cur.inCtrlStrobe_n;
      selected = !cur.inSel1_n && cur.inSel2 && !cur.inSel3_n;
      if (!cur.inAllWrite_n) begin
         writeLanes = '1;
      end else if (!cur.inLaneQual_n) begin
         writeLanes = ~cur.inLaneSel_n;
      end else begin
         writeLanes = '0;
      end
      // A processor-strobe cycle always starts as a read.
      isWrite = (writeLanes != '0) && cur.inProcStrobe_n;
   end

   // Access decision for the cycle that follows the capture edge.
   always_comb begin
      doRead     = 1'b0;
      doWrite    = 1'b0;
      accessAddr = cur.inAddr;
      stepCount  = cur.count;
      if (strobe && !cur.sleepSync) begin
         accessAddr = cur.inAddr;
         doRead     = selected && !isWrite;
         doWrite    = selected && isWrite;
      end else if (cur.mode != PBS_IDLE && !strobe) begin
         if (!cur.inAdvance_n) begin
            stepCount = cur.count + BURST_STEP;
         end
         accessAddr = {cur.baseAddr[ADDR_W-1:BURST_W],
                       burstOffset(cur.inOrder, cur.startOffset,
                                   stepCount)};
         // Sleep holds reads back; queued writes wait in the queue.
         doRead  = !isWrite && !cur.sleepSync;
         doWrite = isWrite;
      end
   end

   // Next-state logic of the whole port.
   always_comb begin
      next_cur = cur;
      next_cur.oeMeta_n  = outputEnable_n;
      next_cur.oeSync_n  = cur.oeMeta_n;
      next_cur.sleepMeta = sleepRequest;
      next_cur.sleepSync = cur.sleepMeta;
      next_cur.inAddr         = address;
      next_cur.inData         = dataPinIn;
      next_cur.inProcStrobe_n = processorAddressStrobe_n;
      next_cur.inCtrlStrobe_n = controllerAddressStrobe_n;
      next_cur.inAdvance_n    = burstAdvance_n;
      next_cur.inAllWrite_n   = allLanesWrite_n;
      next_cur.inLaneQual_n   = laneWriteQualifier_n;
      next_cur.inLaneSel_n    = byteLaneWriteSelect_n;
      next_cur.inSel1_n       = pipelinedChipSelect_n;
      next_cur.inSel2         = depthChipSelectHigh;
      next_cur.inSel3_n       = depthChipSelectLow_n;
      next_cur.inOrder        = burstOrderLinear;
      if (strobe && !cur.sleepSync) begin
         next_cur.mode = !selected ? PBS_IDLE
                       : (isWrite ? PBS_WRITE : PBS_READ);
         next_cur.baseAddr = cur.inAddr;
         next_cur.startOffset = cur.inAddr[BURST_W-1:0];
         next_cur.count       = BURST_FIRST;
      end else if (cur.mode != PBS_IDLE && !strobe) begin
         next_cur.mode  = isWrite ? PBS_WRITE : PBS_READ;
         next_cur.count = stepCount;
      end
      next_cur.readPending = doRead;
      if (cur.readPending) begin
         next_cur.dataOut = arrayRead;
      end
      next_cur.dataEnable = cur.readPending && !cur.oeSync_n;
      next_cur.queueReady = qInReady;
   end

   // State register; the device has no reset of its own but the
   // port holds idle from this one.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   pbs_fifo #(
      .WIDTH (QW),
      .DEPTH (QUEUE_D)
   ) uQueue (
      .clock    (clock),
      .reset    (reset),
      .inValid  (doWrite),
      .inReady  (qInReady),
      .inData   ({accessAddr, cur.inData, writeLanes}),
      .outValid (qOutValid),
      .outReady (!cur.sleepSync),
      .outData  (qOutData)
   );

   pbs_array #(
      .ADDR_W (ADDR_W),
      .LANES  (LANES),
      .LANE_W (LANE_W)
   ) uArray (
      .clock       (clock),
      .writeEnable (qOutValid && !cur.sleepSync),
      .writeAddr   (qOutData[QW-1 -: ADDR_W]),
      .writeData   (qOutData[LANES +: DW]),
      .writeLanes  (qOutData[LANES-1:0]),
      .readEnable  (doRead),
      .readAddr    (accessAddr),
      .readData    (arrayRead)
   );

   // Outputs straight from the state register.
   assign dataPinOut      = cur.dataOut;
   assign dataPinEnable   = cur.dataEnable;
   assign writeQueueReady = cur.queueReady;
endmodule : pbs_port

/* File: test/pbs_port_assertions.sv */
// Purpose: Pin timing checks of the memory port.
// Assumes: Sleep and output enable stay idle around checked reads.
// Notes:   Burst checks use processor strobe starts only.
`timescale 1ns/1ns
module pbs_port_assertions
   import pbs_pkg::*;
#(
   parameter int ADDR_W = WIDE_ADDR_W,
   parameter int LANES  = WIDE_LANES
) (
   input wire logic                    clock,
   input wire logic                    reset,
   input wire logic                    processorAddressStrobe_n,
   input wire logic                    controllerAddressStrobe_n,
   input wire logic                    burstAdvance_n,
   input wire logic                    allLanesWrite_n,
   input wire logic                    pipelinedChipSelect_n,
   input wire logic                    depthChipSelectHigh,
   input wire logic                    depthChipSelectLow_n,
   input wire logic                    outputEnable_n,
   input wire logic                    sleepRequest,
   input wire logic [LANES*LANE_W-1:0] dataPinOut,
   input wire logic                    dataPinEnable,
   input wire logic                    writeQueueReady
);
   logic [3:0] calm;
   logic       sel, quiet, noStb, rdStart, cont, hold, wrStart, desel;
   // Records recent cycles with sleep and output enable idle.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) calm <= 4'h0;
      else calm <= {calm[2:0], !sleepRequest && !outputEnable_n};
   end
   // Decodes the bus cycle seen at the pins.
   assign sel = !pipelinedChipSelect_n && depthChipSelectHigh
                && !depthChipSelectLow_n;
   assign quiet = &calm && !sleepRequest && !outputEnable_n;
   assign noStb = processorAddressStrobe_n && controllerAddressStrobe_n;
   assign rdStart = sel && !processorAddressStrobe_n && quiet;
   assign cont = noStb && !burstAdvance_n && quiet;
   assign hold = noStb && burstAdvance_n && quiet;
   assign wrStart = sel && processorAddressStrobe_n
                    && !controllerAddressStrobe_n && !allLanesWrite_n;
   assign desel = !noStb && !sel;
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   a_first_beat: assert property (rdStart |-> ##3 dataPinEnable)
      else $error("First read beat missing.");
   a_burst_beats: assert property (
      rdStart ##1 cont[*3] |-> dataPinEnable[*4])
      else $error("Burst beats not back to back.");
   a_repeat_beat: assert property (
      rdStart ##1 hold |-> ##3 (dataPinEnable && $stable(dataPinOut)))
      else $error("Held burst changed data.");
   a_deselect_off: assert property (desel |-> ##3 !dataPinEnable)
      else $error("Drive kept after deselect.");
   a_write_quiet: assert property (wrStart |-> ##3 !dataPinEnable)
      else $error("Drive during write.");
   a_oe_release: assert property (
      outputEnable_n[*5] |-> !dataPinEnable)
      else $error("Drive with output enable off.");
   a_sleep_block: assert property (sleepRequest[*6] |-> !dataPinEnable)
      else $error("Drive during sleep.");
   a_queue_ready: assert property (!sleepRequest[*4] |-> writeQueueReady)
      else $error("Write queue not ready.");
   a_reset_idle: assert property (disable iff (1'b0)
      reset |-> !dataPinEnable && dataPinOut == '0)
      else $error("Outputs active in reset.");
   // Main scenarios reached.
   c_burst: cover property (rdStart ##1 cont[*3]);
   c_write: cover property (wrStart);
   c_desel: cover property (desel);
endmodule : pbs_port_assertions

bind pbs_port pbs_port_assertions #(.ADDR_W(ADDR_W), .LANES(LANES)) chk (
   .clock, .reset, .processorAddressStrobe_n, .controllerAddressStrobe_n,
   .burstAdvance_n, .allLanesWrite_n, .pipelinedChipSelect_n,
   .depthChipSelectHigh, .depthChipSelectLow_n, .outputEnable_n,
   .sleepRequest, .dataPinOut, .dataPinEnable, .writeQueueReady);

/* File: test/pbs_master.sv */
// Purpose: Bus master model driving the memory port pins.
// Assumes: One bus cycle per call, changed just after the rising edge.
// Notes:   Released write data flips each cycle so stale data shows.
`timescale 1ns/1ns
module pbs_master
   import pbs_pkg::*;
(
   input  wire logic                    clock,
   output logic [WIDE_ADDR_W-1:0]       address,
   output logic                         processorAddressStrobe_n,
   output logic                         controllerAddressStrobe_n,
   output logic                         burstAdvance_n,
   output logic                         allLanesWrite_n,
   output logic                         laneWriteQualifier_n,
   output logic [WIDE_LANES-1:0]        byteLaneWriteSelect_n,
   output logic                         pipelinedChipSelect_n,
   output logic                         depthChipSelectHigh,
   output logic                         depthChipSelectLow_n,
   output logic [WIDE_LANES*LANE_W-1:0] dataPinIn
);
   // Starts with an idle bus and the part selected.
   initial begin
      {processorAddressStrobe_n, controllerAddressStrobe_n} = 2'h3;
      {burstAdvance_n, allLanesWrite_n, laneWriteQualifier_n} = 3'h7;
      byteLaneWriteSelect_n = 4'hf;
      {pipelinedChipSelect_n, depthChipSelectHigh} = 2'h1;
      depthChipSelectLow_n = 1'h0;
      address = '0;
      dataPinIn = '0;
   end
   task automatic cyc(input logic [4:0] ctl, input logic [3:0] lanes,
      input logic [2:0] off, input logic [18:0] a, input logic [35:0] d);
      @(posedge clock);
      {processorAddressStrobe_n, controllerAddressStrobe_n, burstAdvance_n,
       allLanesWrite_n, laneWriteQualifier_n} <= ctl;
      byteLaneWriteSelect_n <= lanes;
      pipelinedChipSelect_n <= off[0];
      depthChipSelectHigh <= !off[1];
      depthChipSelectLow_n <= off[2];
      address <= a;
      dataPinIn <= (ctl[1:0] != 2'h3) ? d : ~dataPinIn;
   endtask : cyc
endmodule : pbs_master

/* File: test/tb.sv */
// Purpose: Self-checking bench of the memory port.
// Assumes: The master model issues one bus cycle per call.
// Notes:   Read beats are compared against a queue of notes.
`timescale 1ns/1ns
module tb
   import pbs_pkg::*;
();
   typedef logic [WIDE_LANES*LANE_W-1:0] pbs_word_t;
   logic [18:0] address;
   pbs_word_t   dataPinIn, dataPinOut;
   logic [3:0]  byteLaneWriteSelect_n;
   logic        processorAddressStrobe_n, controllerAddressStrobe_n;
   logic        burstAdvance_n, allLanesWrite_n, laneWriteQualifier_n;
   logic        pipelinedChipSelect_n, depthChipSelectHigh;
   logic        depthChipSelectLow_n, dataPinEnable, writeQueueReady;
   logic        clock = 1'h0, reset = 1'h0, burstOrderLinear = 1'h0;
   logic        outputEnable_n = 1'h0, sleepRequest = 1'h0, expectOn = 1'h1;
   pbs_word_t   mem [int];
   pbs_word_t   notes [$];
   int          badCount = 0, comparisons = 0, cycles = 0, desel = 0;

   pbs_master master (.clock, .address, .processorAddressStrobe_n,
      .controllerAddressStrobe_n, .burstAdvance_n, .allLanesWrite_n,
      .laneWriteQualifier_n, .byteLaneWriteSelect_n, .pipelinedChipSelect_n,
      .depthChipSelectHigh, .depthChipSelectLow_n, .dataPinIn);
   pbs_port uut (.clock, .reset, .address, .processorAddressStrobe_n,
      .controllerAddressStrobe_n, .burstAdvance_n, .allLanesWrite_n,
      .laneWriteQualifier_n, .byteLaneWriteSelect_n, .pipelinedChipSelect_n,
      .depthChipSelectHigh, .depthChipSelectLow_n, .burstOrderLinear,
      .outputEnable_n, .sleepRequest, .dataPinIn, .dataPinOut,
      .dataPinEnable, .writeQueueReady);

   always #10 clock = ~clock;

   task automatic completeRun;
      $display("Comparisons %0d, mismatches %0d.", comparisons, badCount);
      if (badCount == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : completeRun

   task automatic fail(input string msg);
      badCount++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask : fail

   function automatic logic [18:0] addrOf(logic [18:0] a, logic [1:0] k);
      return {a[18:2], burstOrderLinear ? a[1:0] + k : a[1:0] ^ k};
   endfunction : addrOf

   task automatic wr(logic [18:0] a, logic gw, q, logic [3:0] lanes);
      pbs_word_t d;
      logic      wrote;
      wrote = 1'h0;
      d = pbs_word_t'({$urandom(), $urandom()});
      master.cyc({3'h5, gw, q}, lanes, 3'h0, a, d);
      for (int i = 0; i < 4; i++)
         if (!gw || (!q && !lanes[i])) begin
            mem[a][9*i+:9] = d[9*i+:9];
            wrote = 1'h1;
         end
      // A controller strobe that selects no lane is a plain read.
      if (!wrote && expectOn) notes.push_back(mem[a]);
   endtask : wr

   task automatic rd(logic [18:0] a, int n, logic ctrl, burst_advance_n);
      logic [1:0] k;
      k = 2'h0;
      master.cyc({!ctrl, ctrl, 3'h7}, 4'hf, 3'h0, a, '0);
      if (expectOn) notes.push_back(mem[addrOf(a, k)]);
      for (int i = 1; i < n; i++) begin
         k = burst_advance_n ? k : k + 2'h1;
         master.cyc({2'h3, burst_advance_n, 2'h3}, 4'hf, 3'h0, a, '0);
         if (expectOn) notes.push_back(mem[addrOf(a, k)]);
      end
      desel = (desel + 1) % 3;
      master.cyc(5'h0f, 4'hf, 3'(1 << desel), a, '0);
   endtask : rd

   // Ends a hung run as a mismatch.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         badCount++;
         completeRun();
      end
   end

   always @(posedge clock) begin
      if (!reset && dataPinEnable === 1'h1) begin
         comparisons++;
         if (notes.size() == 0) fail("unexpected read beat");
         else if (dataPinOut !== notes.pop_front()) fail("read data");
      end
   end

   // Runs the tests in order.
   initial begin
      logic [18:0] base;
      // Raises reset at time zero so no port or queue register starts out unknown.
      reset <= 1'h1;
      void'($urandom(32'hb065));
      repeat (5) @(posedge clock);
      reset <= 1'h0;
      repeat (3) @(posedge clock);
      for (int o = 0; o < 2; o++) begin
         burstOrderLinear <= o[0];
         base = 19'($urandom()) & 19'h7fffc;
         for (int i = 0; i < 4; i++)
            wr(base | 19'(i), 1'h0, 1'h0, 4'($urandom()));
         rd(base | 19'($urandom() % 4), 4, o[0], 1'h0);
         rd(base, 3, 1'h0, 1'h1);
         $display("Test burst order %0d done.", o);
      end
      for (int i = 0; i < 6; i++) begin
         wr(base, 1'h1, i == 5, 4'($urandom()));
         rd(base, 1, i[0], 1'h0);
      end
      $display("Test byte lanes done.");
      for (int t = 0; t < 2; t++) begin
         repeat (4) @(posedge clock);
         if (t == 0) outputEnable_n <= 1'h1;
         else sleepRequest <= 1'h1;
         expectOn = 1'h0;
         repeat (6) @(posedge clock);
         rd(base, 2, 1'h0, 1'h0);
         outputEnable_n <= 1'h0;
         sleepRequest <= 1'h0;
         expectOn = 1'h1;
         repeat (6) @(posedge clock);
         rd(base, 1, 1'h1, 1'h0);
         $display("Test hold off %0d done.", t);
      end
      repeat (6) @(posedge clock);
      comparisons++;
      if (notes.size() != 0) fail("read beats missing");
      completeRun();
   end
endmodule : tb
